// File: tcu_pkg.sv
// Purpose: Shared constants for the timer compare and interrupt unit
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes: Offsets are byte addresses
package tcu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] TCU_OFS_CTRL = 8'h00;
    localparam logic [7:0] TCU_OFS_IRQ_EN = 8'h04;
    localparam logic [7:0] TCU_OFS_STATUS = 8'h08;
    localparam logic [7:0] TCU_OFS_CMP_ONE = 8'h0C;
    localparam logic [7:0] TCU_OFS_CMP_TWO = 8'h10;
    localparam logic [7:0] TCU_OFS_COUNT = 8'h14;
    localparam logic [7:0] TCU_OFS_FORCE = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int TCU_CTRL_CLKSEL_LSB = 0;   // 2 bits
    localparam int TCU_CTRL_EXT_EDGE = 2;     // 1 = rising edge
    localparam int TCU_CTRL_LEVEL_ONE = 3;    // Level driven on match, channel one
    localparam int TCU_CTRL_LEVEL_TWO = 4;
    localparam int TCU_CTRL_FORCE_ONE = 5;    // Forced-compare select, channel one
    localparam int TCU_CTRL_FORCE_TWO = 6;
    localparam int TCU_CTRL_ACTIVE_ONE = 7;   // Channel enabled for normal compare
    localparam int TCU_CTRL_ACTIVE_TWO = 8;
    localparam int TCU_CTRL_W = 9;

    // Interrupt enable and status bits share one layout
    localparam int TCU_IRQ_CMP_ONE = 0;
    localparam int TCU_IRQ_CMP_TWO = 1;
    localparam int TCU_IRQ_CAPTURE = 2;
    localparam int TCU_IRQ_WRAP = 3;
    localparam int TCU_IRQ_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Clock select codes and reset values
    typedef enum logic [1:0] {
        TCU_CLK_DIV2 = 2'b00,
        TCU_CLK_DIV4 = 2'b01,
        TCU_CLK_DIV8 = 2'b10,
        TCU_CLK_EXT = 2'b11
    } tcu_clksel_e;

    localparam logic [8:0] TCU_CTRL_RESET = 9'h001;   // Divide by four
    localparam logic [15:0] TCU_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TCU_CMP_RESET = 16'hFFFF;
    localparam logic [2:0] TCU_PRESCALE_RESET = 3'h0;

endpackage : tcu_pkg

// File: tcu_tick_gen.sv
// Purpose: Counter tick source: prescaled system clock or external edge
// Assumes: ext_clk is asynchronous to clk
// Notes: External clock must be slower than clk / 4
`timescale 1ns/100ps
module tcu_tick_gen
    import tcu_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] clk_sel,
    input wire logic ext_rise,
    input wire logic ext_clk,
    output logic tick
);

    logic [2:0] pre_ff;
    logic [2:0] nxt_pre;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_last_ff;
    logic tick_ff;
    logic nxt_tick;
    wire ext_edge;
    wire pre_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler compare picks the divider
    assign nxt_pre = pre_ff + 3'h1;
    assign pre_hit = (clk_sel == TCU_CLK_DIV2) ? (pre_ff[0] == 1'b1) :
                     (clk_sel == TCU_CLK_DIV4) ? (pre_ff[1:0] == 2'b11) :
                     (pre_ff == 3'b111);   // [R14]
    // Edge detect compares the second stage with its delayed copy
    assign ext_edge = ext_rise ? (ext_sync_ff & ~ext_last_ff) : (~ext_sync_ff & ext_last_ff);   // [R15]
    assign nxt_tick = (clk_sel == TCU_CLK_EXT) ? ext_edge : pre_hit;

    // Prescaler and two-stage synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_ff <= TCU_PRESCALE_RESET;
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_last_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff <= nxt_pre;
            ext_meta_ff <= ext_clk;
            ext_sync_ff <= ext_meta_ff;
            ext_last_ff <= ext_sync_ff;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : tcu_tick_gen

// File: tcu_timer_compare.sv
// Purpose: Two-channel output compare with maskable interrupt sources
// Assumes: Classic Wishbone slave, single clock, capture events from outside
// Notes: Status bits clear on read; set wins over the clearing read
//   The bus answers one cycle after the request edge; ack lasts one cycle
//   A compare value written on a match edge loses that match
//   The counter cannot be loaded, so a wrap needs 65536 ticks
//   Forced compare ignores the stored value; only the strobe acts
//   The prescaler runs free, so the first tick after a rate change may come early
//   Capture events arrive already in this clock domain
//   The external clock passes two flip-flops before its edge is seen
//   The global processor mask lives outside this block
//
// Function
// (R01) Compare interrupt enable lets a flagged compare event raise the interrupt.
// (R02) Capture interrupt enable lets a flagged capture event raise the interrupt.
// (R03) Wrap interrupt enable lets a counter overflow raise the interrupt.
// (R04) Each enable masks only its own flag; several change in one write.
// (R05) The processor also needs its global mask cleared before servicing.
// (R06) Two independent compare channels with own value, level and flag.
// (R07) Compare values are full 16 bits, any value accepted.
// (R08) Low level setting drives the channel pin low on match.
// (R09) High level setting drives the channel pin high on match.
// (R10) A match on an active channel sets that channel's flag.
// (R11) Each channel can use forced compare instead of normal compare.
// (R12) In forced compare the stored value does not shape the pin.
// (R13) Matching compares each value against a free-running 16-bit counter.
// (R14) Counter clock is system clock over 2, 4 or 8; 4 at reset.
// (R15) Counter may instead count external clock rising or falling edges.
// (R16) Wrap from maximum to zero sets the overflow flag.
`timescale 1ns/100ps
module tcu_timer_compare
    import tcu_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic capture_event,
    input wire logic ext_clk,
    output logic compare_channel_one,
    output logic compare_channel_two,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [TCU_CTRL_W-1:0] ctrl_ff;
    logic [TCU_IRQ_W-1:0] irq_en_ff;
    logic [TCU_IRQ_W-1:0] status_ff;
    logic [15:0] compare_value_one_ff;
    logic [15:0] compare_value_two_ff;
    logic [15:0] count_ff;
    logic pin_one_ff;
    logic pin_two_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;
    logic [TCU_IRQ_W-1:0] nxt_status;
    logic [15:0] nxt_count;
    logic [31:0] nxt_rdata;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr_go = bus_req & wb_we_i;
    wire rd_go = bus_req & ~wb_we_i;
    wire hit_ctrl = (wb_adr_i == TCU_OFS_CTRL);
    wire hit_irq_en = (wb_adr_i == TCU_OFS_IRQ_EN);
    wire hit_status = (wb_adr_i == TCU_OFS_STATUS);
    wire hit_cmp_one = (wb_adr_i == TCU_OFS_CMP_ONE);
    wire hit_cmp_two = (wb_adr_i == TCU_OFS_CMP_TWO);
    wire hit_count = (wb_adr_i == TCU_OFS_COUNT);
    wire hit_force = (wb_adr_i == TCU_OFS_FORCE);

    // Apply byte enables to a 32-bit old value
    function automatic logic [31:0] tcu_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : tcu_merge

    wire [31:0] ctrl_merged = tcu_merge({23'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] irq_en_merged = tcu_merge({28'h0, irq_en_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] cmp_one_merged = tcu_merge({16'h0, compare_value_one_ff}, wb_dat_i, wb_sel_i);   // [R07]
    wire [31:0] cmp_two_merged = tcu_merge({16'h0, compare_value_two_ff}, wb_dat_i, wb_sel_i);   // [R07]

    ////////////////////////////////////////////////////////////////////////////
    // Tick source
    tcu_tick_gen u_tick (
        .clk(clk),
        .rstn(rstn),
        .clk_sel(ctrl_ff[TCU_CTRL_CLKSEL_LSB +: 2]),
        .ext_rise(ctrl_ff[TCU_CTRL_EXT_EDGE]),
        .ext_clk(ext_clk),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter and compare decode
    assign nxt_count = tick ? count_ff + 16'h0001 : count_ff;   // [R13]
    wire wrap = tick & (count_ff == 16'hFFFF);   // [R16]
    // Match taken on the tick that lands on the value, so each count is seen once
    wire match_one = tick & ctrl_ff[TCU_CTRL_ACTIVE_ONE] & ~ctrl_ff[TCU_CTRL_FORCE_ONE] &
                     (nxt_count == compare_value_one_ff);   // [R13]
    wire match_two = tick & ctrl_ff[TCU_CTRL_ACTIVE_TWO] & ~ctrl_ff[TCU_CTRL_FORCE_TWO] &
                     (nxt_count == compare_value_two_ff);   // [R13]
    // Forced compare: a software strobe, value ignored
    wire force_one = wr_go & hit_force & wb_sel_i[0] & wb_dat_i[0] & ctrl_ff[TCU_CTRL_FORCE_ONE];   // [R12]
    wire force_two = wr_go & hit_force & wb_sel_i[0] & wb_dat_i[1] & ctrl_ff[TCU_CTRL_FORCE_TWO];   // [R12]
    wire event_one = match_one | force_one;   // [R11]
    wire event_two = match_two | force_two;   // [R11]

    // Event sets beat the clear-on-read
    wire [TCU_IRQ_W-1:0] set_vec = {wrap, capture_event, event_two, event_one};
    wire status_rd = rd_go & hit_status;
    assign nxt_status = (status_rd ? {TCU_IRQ_W{1'b0}} : status_ff) | set_vec;   // [R10]
    // Interrupt level: each enable gates only its own flag
    wire nxt_irq = |(nxt_status & irq_en_ff);   // [R01] [R02] [R03] [R04]

    // Read mux; unmapped addresses read zero
    assign nxt_rdata = hit_ctrl ? {23'h0, ctrl_ff} :
                       hit_irq_en ? {28'h0, irq_en_ff} :
                       hit_status ? {28'h0, status_ff} :
                       hit_cmp_one ? {16'h0, compare_value_one_ff} :
                       hit_cmp_two ? {16'h0, compare_value_two_ff} :
                       hit_count ? {16'h0, count_ff} :
                       32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= TCU_CTRL_RESET;   // [R14]
            irq_en_ff <= {TCU_IRQ_W{1'b0}};
            compare_value_one_ff <= TCU_CMP_RESET;
            compare_value_two_ff <= TCU_CMP_RESET;
        end else begin
            if (wr_go && hit_ctrl) begin
                ctrl_ff <= ctrl_merged[TCU_CTRL_W-1:0];
            end
            if (wr_go && hit_irq_en) begin
                irq_en_ff <= irq_en_merged[TCU_IRQ_W-1:0];   // [R04]
            end
            if (wr_go && hit_cmp_one) begin
                compare_value_one_ff <= cmp_one_merged[15:0];   // [R06]
            end
            if (wr_go && hit_cmp_two) begin
                compare_value_two_ff <= cmp_two_merged[15:0];   // [R06]
            end
        end
    end

    // Counter, status and pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= TCU_COUNT_RESET;
            status_ff <= {TCU_IRQ_W{1'b0}};
            pin_one_ff <= 1'b0;
            pin_two_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            status_ff <= nxt_status;
            irq_ff <= nxt_irq;
            if (event_one) begin
                pin_one_ff <= ctrl_ff[TCU_CTRL_LEVEL_ONE];   // [R08] [R09]
            end
            if (event_two) begin
                pin_two_ff <= ctrl_ff[TCU_CTRL_LEVEL_TWO];   // [R08] [R09]
            end
        end
    end

    // Bus answer, one wait state, dropped the cycle after
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            rdata_ff <= rd_go ? nxt_rdata : rdata_ff;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign compare_channel_one = pin_one_ff;
    assign compare_channel_two = pin_two_ff;
    assign irq = irq_ff;   // [R05] Processor applies its own global mask

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_irq_gating: assert property (@(posedge clk) disable iff (!rstn)
        irq == |($past(nxt_status) & $past(irq_en_ff)))   // [R04]
        else $error("irq does not follow enabled flags");
    chk_cmp_irq: assert property (@(posedge clk) disable iff (!rstn)
        (event_one && irq_en_ff[TCU_IRQ_CMP_ONE]) |=> irq)   // [R01]
        else $error("compare event with enable gave no irq");
    chk_cap_irq: assert property (@(posedge clk) disable iff (!rstn)
        (capture_event && irq_en_ff[TCU_IRQ_CAPTURE]) |=> irq)   // [R02]
        else $error("capture event with enable gave no irq");
    chk_wrap_irq: assert property (@(posedge clk) disable iff (!rstn)
        (wrap && irq_en_ff[TCU_IRQ_WRAP]) |=> irq && status_ff[TCU_IRQ_WRAP])   // [R03]
        else $error("wrap with enable gave no irq");
    chk_match_flag: assert property (@(posedge clk) disable iff (!rstn)
        match_two |=> status_ff[TCU_IRQ_CMP_TWO] && count_ff == compare_value_two_ff)   // [R10]
        else $error("channel two match did not set flag");
    chk_pin_level: assert property (@(posedge clk) disable iff (!rstn)
        event_one |=> compare_channel_one == $past(ctrl_ff[TCU_CTRL_LEVEL_ONE]))   // [R08]
        else $error("channel one pin wrong level after match");
    chk_force_ignores: assert property (@(posedge clk) disable iff (!rstn)
        (ctrl_ff[TCU_CTRL_FORCE_TWO] && !force_two) |=> $stable(compare_channel_two))   // [R12]
        else $error("forced channel two pin moved without strobe");
    chk_wrap_zero: assert property (@(posedge clk) disable iff (!rstn)
        wrap |=> count_ff == 16'h0000 ##0 status_ff[TCU_IRQ_WRAP])   // [R16]
        else $error("wrap did not land on zero with flag");
    chk_div_four: assert property (@(posedge clk) disable iff (!rstn)
        (tick && ctrl_ff[1:0] == TCU_CLK_DIV4 && $past(ctrl_ff[1:0]) == TCU_CLK_DIV4 && !(wr_go && hit_ctrl))
        ##1 (ctrl_ff[1:0] == TCU_CLK_DIV4) [*3]
        |-> !$past(tick) && !$past(tick, 2))   // [R14]
        else $error("divide by four ticked too soon");

    ////////////////////////////////////////////////////////////////////////////
    // Bus, flag and counter checks
    // Rate checks need the rate steady for two cycles, since the
    // prescaler keeps its phase across a change of divider.
    // Pin hold checks guard channel independence: only a channel's
    // own event may move its pin.
    // Readback checks compare the bus word with the register it shows.
    // The wrap checks above need a full count and stay idle in short runs.

    // One answer per request
    chk_ack_answer: assert property (@(posedge clk) disable iff (!rstn)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request got no ack");

    // Ack is a single-cycle pulse
    chk_ack_pulse: assert property (@(posedge clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // No ack without a request
    chk_ack_idle: assert property (@(posedge clk) disable iff (!rstn)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");

    // Capture flag is set by its event
    chk_cap_flag: assert property (@(posedge clk) disable iff (!rstn)
        capture_event |=> status_ff[TCU_IRQ_CAPTURE])   // [R02]
        else $error("capture did not set flag");

    // Flag stays until read
    chk_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
        (status_ff[TCU_IRQ_CAPTURE] && !status_rd) |=> status_ff[TCU_IRQ_CAPTURE])   // [R02]
        else $error("capture flag lost without read");

    // Read clears when no new event
    chk_read_clears: assert property (@(posedge clk) disable iff (!rstn)
        (status_rd && !capture_event) |=> !status_ff[TCU_IRQ_CAPTURE])   // [R02]
        else $error("status read did not clear flag");

    // No enables, no interrupt
    chk_irq_masked: assert property (@(posedge clk) disable iff (!rstn)
        (irq_en_ff == {TCU_IRQ_W{1'b0}}) |=> !irq)   // [R04]
        else $error("irq raised with all enables clear");

    // Channel one match sets its flag
    chk_match_one: assert property (@(posedge clk) disable iff (!rstn)
        match_one |=> status_ff[TCU_IRQ_CMP_ONE])   // [R10]
        else $error("channel one match did not set flag");

    // Channel two pin takes its level
    chk_pin_two: assert property (@(posedge clk) disable iff (!rstn)
        event_two |=> compare_channel_two == $past(ctrl_ff[TCU_CTRL_LEVEL_TWO]))   // [R09]
        else $error("channel two pin wrong level after match");

    // Forced strobe drives channel one
    chk_force_one: assert property (@(posedge clk) disable iff (!rstn)
        force_one |=> compare_channel_one == $past(ctrl_ff[TCU_CTRL_LEVEL_ONE]))   // [R11]
        else $error("forced strobe did not drive channel one");

    // Forced channel one never matches
    chk_force_nomatch: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_ff[TCU_CTRL_FORCE_ONE] |-> !match_one)   // [R12]
        else $error("forced channel one matched its value");

    // Channel one pin moves only on its event
    chk_hold_one: assert property (@(posedge clk) disable iff (!rstn)
        !event_one |=> $stable(compare_channel_one))   // [R06]
        else $error("channel one pin moved without event");

    // Channel two pin moves only on its event
    chk_hold_two: assert property (@(posedge clk) disable iff (!rstn)
        !event_two |=> $stable(compare_channel_two))   // [R06]
        else $error("channel two pin moved without event");

    // Counter steps by one per tick
    chk_count_step: assert property (@(posedge clk) disable iff (!rstn)
        tick |=> count_ff == $past(count_ff) + 16'h0001)   // [R13]
        else $error("counter did not step on tick");

    // Counter holds between ticks
    chk_count_hold: assert property (@(posedge clk) disable iff (!rstn)
        !tick |=> $stable(count_ff))   // [R13]
        else $error("counter moved without tick");

    // Divide by two spacing
    chk_div_two: assert property (@(posedge clk) disable iff (!rstn)
        (tick && ctrl_ff[1:0] == TCU_CLK_DIV2 && $past(ctrl_ff[1:0]) == TCU_CLK_DIV2) |=> !tick)   // [R14]
        else $error("divide by two ticked too soon");

    // Divide by eight spacing
    chk_div_eight: assert property (@(posedge clk) disable iff (!rstn)
        (tick && ctrl_ff[1:0] == TCU_CLK_DIV8 && $past(ctrl_ff[1:0]) == TCU_CLK_DIV8) |=> !tick)   // [R14]
        else $error("divide by eight ticked too soon");

    // Status read returns the flags
    chk_status_read: assert property (@(posedge clk) disable iff (!rstn)
        status_rd |=> wb_dat_o[TCU_IRQ_W-1:0] == $past(status_ff))   // [R10]
        else $error("status read data wrong");

    // Enable read returns the enables
    chk_en_read: assert property (@(posedge clk) disable iff (!rstn)
        (rd_go && hit_irq_en) |=> wb_dat_o[TCU_IRQ_W-1:0] == $past(irq_en_ff))   // [R04]
        else $error("enable read data wrong");

    // Channel one flag set by a forced strobe
    chk_force_flag: assert property (@(posedge clk) disable iff (!rstn)
        force_one |=> status_ff[TCU_IRQ_CMP_ONE])   // [R11]
        else $error("forced strobe did not set flag");

endmodule : tcu_timer_compare

// File: tcu_timer_compare_tb.sv
// Purpose: Self-checking bench for the timer compare and interrupt unit
// Assumes: Wishbone answer one cycle after the request is taken, one 50 MHz clock
// Notes: Counter wrap needs 131072 cycles even at the fastest rate, so it is not run here
`timescale 1ns/100ps
module tcu_timer_compare_tb import tcu_pkg::*; ();
    logic clk, rstn, cyc, stb, we, ack, cap, ext_clk, pin1, pin2, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r, q, seed;
    int n_errors, compares, cycles, c1, c2, t1, t2, e, d, exp_en, exp_status;
    localparam logic [7:0] TCU_RST_ADR [6] = '{TCU_OFS_CTRL, TCU_OFS_IRQ_EN, TCU_OFS_STATUS,
        TCU_OFS_CMP_ONE, TCU_OFS_CMP_TWO, 8'h1C};
    localparam logic [31:0] TCU_RST_VAL [6] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
        32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0000};
    ////////////////////////////////////////////////////////////////////////////
    // Clock, reset, and a ceiling well above the thousand or so cycles needed
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    tcu_timer_compare i_tcu_timer_compare (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .capture_event(cap), .ext_clk(ext_clk), .compare_channel_one(pin1), .compare_channel_two(pin2),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [31:0] bit_of(input int n);
        return 32'h0000_0001 << n;
    endfunction : bit_of
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= dw;
        sel <= 4'hF;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic rd_count(output int c, output int t);
        wb(1'b0, TCU_OFS_COUNT, 32'h0000_0000);
        c = int'(q[15:0]);
        t = cycles;
    endtask : rd_count
    // Level interrupt is the OR of enabled sticky bits, one cycle late
    task automatic check_irq();
        repeat (2) @(negedge clk);
        check("irq", 32'(|(exp_status & exp_en)), 32'(irq));
    endtask : check_irq
    task automatic wait_pin(input int ch, input logic lvl);
        int n;
        n = 0;
        while (((ch == 1) ? pin1 : pin2) !== lvl && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("compare pin", 32'(lvl), 32'((ch == 1) ? pin1 : pin2));
    endtask : wait_pin
    task automatic ext_pulses();
        repeat (10) begin
            repeat (6) @(posedge clk);
            ext_clk <= 1'b1;
            repeat (6) @(posedge clk);
            ext_clk <= 1'b0;
        end
        repeat (6) @(posedge clk);
    endtask : ext_pulses
    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rstn, cyc, stb, we, cap, ext_clk} = 6'h00;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0000_0000;
        seed = 32'h0000_11B4;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, unmapped place reads zero
        foreach (TCU_RST_ADR[i]) begin
            wb(1'b0, TCU_RST_ADR[i], 32'h0000_0000);
            check("reset value", TCU_RST_VAL[i], q);
        end
        // Both ends of the compare range stored on both channels
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, (k < 2) ? TCU_OFS_CMP_ONE : TCU_OFS_CMP_TWO, (k % 2) ? 32'h0000_FFFF : 32'h0000_0000);
            wb(1'b0, (k < 2) ? TCU_OFS_CMP_ONE : TCU_OFS_CMP_TWO, 32'h0000_0000);
            check("compare value", (k % 2) ? 32'h0000_FFFF : 32'h0000_0000, q);
        end
        // Prescaled rates: free prescaler allows one count of slack
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, TCU_OFS_CTRL, 32'(k));
            rd_count(c1, t1);
            repeat (60) @(posedge clk);
            rd_count(c2, t2);
            d = (c2 - c1) & 32'h0000_FFFF;
            e = (t2 - t1) >> (k + 1);
            check("count rate", 32'h0000_0001, 32'(d >= e - 1 && d <= e + 1));
        end
        // External clock, rising then falling edges
        for (int k = 1; k >= 0; k--) begin
            wb(1'b1, TCU_OFS_CTRL, 32'(TCU_CLK_EXT) | (k ? bit_of(TCU_CTRL_EXT_EDGE) : 32'h0000_0000));
            rd_count(c1, t1);
            ext_pulses();
            rd_count(c2, t2);
            check("ext count", 32'h0000_000A, 32'((c2 - c1) & 32'h0000_FFFF));
        end
        // Capture flag masked, then enabled with another source in one write
        exp_en = bit_of(TCU_IRQ_CMP_ONE);
        wb(1'b1, TCU_OFS_IRQ_EN, 32'(exp_en));
        @(posedge clk);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
        exp_status = bit_of(TCU_IRQ_CAPTURE);
        check_irq();
        exp_en = bit_of(TCU_IRQ_CMP_ONE) | bit_of(TCU_IRQ_CMP_TWO) | bit_of(TCU_IRQ_CAPTURE);
        wb(1'b1, TCU_OFS_IRQ_EN, 32'(exp_en));
        check_irq();
        wb(1'b0, TCU_OFS_IRQ_EN, 32'h0000_0000);
        check("irq enable", 32'(exp_en), q);
        wb(1'b0, TCU_OFS_STATUS, 32'h0000_0000);
        check("status", 32'(exp_status), q);
        exp_status = 0;
        check_irq();
        // Channel one: high level on a random match ahead of the counter
        wb(1'b1, TCU_OFS_CTRL, bit_of(TCU_CTRL_LEVEL_ONE) | bit_of(TCU_CTRL_ACTIVE_ONE));
        rd_count(c1, t1);
        seed = lfsr_next(seed);
        wb(1'b1, TCU_OFS_CMP_ONE, 32'((c1 + 20 + seed[4:0]) & 32'h0000_FFFF));
        check("pin before match", 32'h0000_0000, 32'(pin1));
        wait_pin(1, 1'b1);
        exp_status = bit_of(TCU_IRQ_CMP_ONE);
        check_irq();
        wb(1'b0, TCU_OFS_STATUS, 32'h0000_0000);
        check("status", 32'(exp_status), q);
        exp_status = 0;
        // Channel two forced: a near compare value must not act
        wb(1'b1, TCU_OFS_CTRL, bit_of(TCU_CTRL_LEVEL_TWO) | bit_of(TCU_CTRL_FORCE_TWO) | bit_of(TCU_CTRL_ACTIVE_TWO));
        rd_count(c1, t1);
        wb(1'b1, TCU_OFS_CMP_TWO, 32'((c1 + 6) & 32'h0000_FFFF));
        repeat (40) @(posedge clk);
        check("forced pin idle", 32'h0000_0000, 32'(pin2));
        check_irq();
        wb(1'b1, TCU_OFS_FORCE, bit_of(1));
        wait_pin(2, 1'b1);
        exp_status = bit_of(TCU_IRQ_CMP_TWO);
        check_irq();
        wb(1'b0, TCU_OFS_STATUS, 32'h0000_0000);
        check("status", 32'(exp_status), q);
        exp_status = 0;
        // Channel two normal, low level; channel one must keep its level
        wb(1'b1, TCU_OFS_CTRL, bit_of(TCU_CTRL_ACTIVE_TWO));
        rd_count(c1, t1);
        seed = lfsr_next(seed);
        wb(1'b1, TCU_OFS_CMP_TWO, 32'((c1 + 20 + seed[4:0]) & 32'h0000_FFFF));
        wait_pin(2, 1'b0);
        check("other pin", 32'h0000_0001, 32'(pin1));
        wb(1'b0, TCU_OFS_STATUS, 32'h0000_0000);
        check("status", bit_of(TCU_IRQ_CMP_TWO), q);
        tally_and_finish();
    end
endmodule : tcu_timer_compare_tb
